// file: mode_reg_pkg.sv
// Field layout, codes and limits of the two feature mode registers
package mode_reg_pkg;
   // ------------------------------------------------------------
   // Command word and register select
   // ------------------------------------------------------------
   localparam int unsigned MR_WIDTH = 19;
   localparam logic [2:0] SEL_MODE_REGISTER_ONE = 3'h1;
   localparam logic [2:0] SEL_MODE_REGISTER_TWO = 3'h2;
   localparam logic [18:0] MODE_REGISTER_ONE_RESET = 19'h00000;
   localparam logic [18:0] MODE_REGISTER_TWO_RESET = 19'h00000;
   // ------------------------------------------------------------
   // Mode register one fields
   // ------------------------------------------------------------
   localparam int unsigned MR1_TERM_STROBE_BIT = 11;
   localparam int unsigned MR1_NOM_TERM_HI_BIT = 9;
   localparam int unsigned MR1_NOM_TERM_MID_BIT = 6;
   localparam int unsigned MR1_NOM_TERM_LO_BIT = 2;
   localparam int unsigned MR1_WRITE_LEVEL_BIT = 7;
   localparam int unsigned MR1_ADD_LAT_HI_BIT = 4;
   localparam int unsigned MR1_ADD_LAT_LO_BIT = 3;
   // ------------------------------------------------------------
   // Mode register two fields
   // ------------------------------------------------------------
   localparam int unsigned MR2_CWL_LSB = 3;
   localparam int unsigned MR2_AUTO_SR_BIT = 6;
   localparam int unsigned MR2_SR_TEMP_BIT = 7;
   localparam int unsigned MR2_WR_TERM_HI_BIT = 10;
   localparam int unsigned MR2_WR_TERM_LO_BIT = 9;
   localparam logic [18:0] MR2_RESERVED_MASK = 19'h4f907;
   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] AL_ZERO = 2'h0;
   localparam logic [1:0] AL_CL_MINUS_ONE = 2'h1;
   localparam logic [1:0] AL_CL_MINUS_TWO = 2'h2;
   localparam logic [3:0] CWL_BASE = 4'h5;
   localparam logic [2:0] NOM_TERM_OFF = 3'h0;
   localparam int unsigned TEMP_SWITCH_C = 85;
   // Termination divisors of RZQ by nominal code 1..5
   localparam logic [3:0] DIV_CODE1 = 4'h4;
   localparam logic [3:0] DIV_CODE2 = 4'h2;
   localparam logic [3:0] DIV_CODE3 = 4'h6;
   localparam logic [3:0] DIV_CODE4 = 4'hc;
   localparam logic [3:0] DIV_CODE5 = 4'h8;
   typedef enum logic [1:0] {TERM_HIGH_Z, TERM_NOMINAL, TERM_WRITE} term_sel_t;
endpackage

// file: mode_reg_features.sv
// Feature decode of mode registers one and two with termination control
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/10ps
module mode_reg_features #(
   parameter int unsigned X8_PART = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mrs_valid,
   input wire logic [2:0] mrs_select,
   input wire logic [18:0] mrs_data,
   input wire logic [3:0] cas_latency,
   input wire logic init_done,
   input wire logic read_active,
   input wire logic self_refresh,
   input wire logic write_burst,
   input wire logic hot_case,
   input wire logic termination_pin,
   output logic termination_strobe_active,
   output logic termination_strobe_n_used,
   output logic data_mask_enable,
   output logic termination_on,
   output logic [1:0] termination_select,
   output logic [3:0] nominal_termination,
   output logic [1:0] write_termination,
   output logic write_leveling,
   output logic [3:0] additive_latency,
   output logic additive_latency_reserved,
   output logic [3:0] cas_write_latency,
   output logic [4:0] overall_write_latency,
   output logic automatic_self_refresh,
   output logic self_refresh_temperature,
   output logic double_refresh_rate
);
   initial begin
      if (X8_PART > 1) $error("X8_PART must be 0 or 1");
   end

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // Mode registers
   // ------------------------------------------------------------
   logic [18:0] mode_register_one;
   // Power-up value only; reset never reaches register two
   logic [18:0] mode_register_two = mode_reg_pkg::MODE_REGISTER_TWO_RESET;
   wire load_one = mrs_valid && mrs_select == mode_reg_pkg::SEL_MODE_REGISTER_ONE;
   wire load_two = mrs_valid && mrs_select == mode_reg_pkg::SEL_MODE_REGISTER_TWO;
   // Reserved bits are stored as given; the controller model zeroes them for register two only
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         mode_register_one <= mode_reg_pkg::MODE_REGISTER_ONE_RESET;
      end else if (load_one) begin
         mode_register_one <= mrs_data;
      end
   end
   // Register two is outside the reset's reach: only a load_two write changes it after power-up
   always_ff @(posedge clk) begin
      if (load_two) begin
         mode_register_two <= mrs_data;
      end
   end

   // ------------------------------------------------------------
   // Field decode
   // ------------------------------------------------------------
   wire strobe_bit = mode_register_one[mode_reg_pkg::MR1_TERM_STROBE_BIT];
   wire strobe_en = strobe_bit && X8_PART == 1;
   wire [2:0] nom_code = {mode_register_one[mode_reg_pkg::MR1_NOM_TERM_HI_BIT],
      mode_register_one[mode_reg_pkg::MR1_NOM_TERM_MID_BIT],
      mode_register_one[mode_reg_pkg::MR1_NOM_TERM_LO_BIT]};
   wire [1:0] al_code = {mode_register_one[mode_reg_pkg::MR1_ADD_LAT_HI_BIT],
      mode_register_one[mode_reg_pkg::MR1_ADD_LAT_LO_BIT]};
   wire wl_bit = mode_register_one[mode_reg_pkg::MR1_WRITE_LEVEL_BIT];
   wire [1:0] wr_code = {mode_register_two[mode_reg_pkg::MR2_WR_TERM_HI_BIT],
      mode_register_two[mode_reg_pkg::MR2_WR_TERM_LO_BIT]};
   wire [2:0] cwl_code = mode_register_two[mode_reg_pkg::MR2_CWL_LSB +: 3];
   wire asr_bit = mode_register_two[mode_reg_pkg::MR2_AUTO_SR_BIT];
   wire srt_bit = mode_register_two[mode_reg_pkg::MR2_SR_TEMP_BIT];

   logic [3:0] next_divisor;
   always_comb begin
      case (nom_code)
         3'h1: next_divisor = mode_reg_pkg::DIV_CODE1;
         3'h2: next_divisor = mode_reg_pkg::DIV_CODE2;
         3'h3: next_divisor = mode_reg_pkg::DIV_CODE3;
         3'h4: next_divisor = mode_reg_pkg::DIV_CODE4;
         3'h5: next_divisor = mode_reg_pkg::DIV_CODE5;
         default: next_divisor = 4'h0;
      endcase
   end

   logic [3:0] next_al;
   always_comb begin
      case (al_code)
         mode_reg_pkg::AL_ZERO: next_al = 4'h0;
         mode_reg_pkg::AL_CL_MINUS_ONE: next_al = cas_latency - 4'h1;
         mode_reg_pkg::AL_CL_MINUS_TWO: next_al = cas_latency - 4'h2;
         default: next_al = 4'h0;
      endcase
   end

   wire [3:0] next_cwl = mode_reg_pkg::CWL_BASE + {1'b0, cwl_code};
   wire [4:0] next_wl = {1'b0, next_cwl} + {1'b0, next_al};

   // ------------------------------------------------------------
   // Termination control
   // ------------------------------------------------------------
   wire nom_enabled = nom_code != mode_reg_pkg::NOM_TERM_OFF;
   // A reading or self refreshing device never terminates, whatever the pin says
   wire term_allowed = init_done && !read_active && !self_refresh;
   wire dyn_enabled = wr_code != 2'h0 && !wl_bit;
   wire write_phase = dyn_enabled && write_burst && termination_pin;
   wire nom_phase = nom_enabled && termination_pin && !write_phase;
   wire next_on = term_allowed && (nom_phase || write_phase);
   mode_reg_pkg::term_sel_t next_sel;
   assign next_sel = !next_on ? mode_reg_pkg::TERM_HIGH_Z :
      write_phase ? mode_reg_pkg::TERM_WRITE : mode_reg_pkg::TERM_NOMINAL;

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         termination_on <= 1'b0;
         termination_select <= 2'h0;
         termination_strobe_active <= 1'b0;
         nominal_termination <= 4'h0;
         write_termination <= 2'h0;
         write_leveling <= 1'b0;
         additive_latency <= 4'h0;
         additive_latency_reserved <= 1'b0;
         cas_write_latency <= 4'h0;
         overall_write_latency <= 5'h00;
         automatic_self_refresh <= 1'b0;
         self_refresh_temperature <= 1'b0;
         double_refresh_rate <= 1'b0;
      end else begin
         termination_on <= next_on;
         termination_select <= 2'(next_sel);
         termination_strobe_active <= strobe_en && next_on;
         nominal_termination <= next_divisor;
         write_termination <= wr_code;
         write_leveling <= wl_bit;
         additive_latency <= next_al;
         additive_latency_reserved <= al_code == 2'h3;
         cas_write_latency <= next_cwl;
         overall_write_latency <= next_wl;
         automatic_self_refresh <= asr_bit;
         self_refresh_temperature <= srt_bit;
         double_refresh_rate <= srt_bit || (asr_bit && hot_case);
      end
   end

   // Ball sharing follows the stored bit directly on X8 parts; with X8_PART 0 the data mask stays enabled
   assign data_mask_enable = !strobe_en;
   assign termination_strobe_n_used = strobe_en;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_read_blocks_term: assert property (@(posedge clk) disable iff (!rst_sync)
      read_active |=> !termination_on) else $error("termination on during read");
   a_pin_drives_term: assert property (@(posedge clk) disable iff (!rst_sync)
      (init_done && !read_active && !self_refresh && nom_enabled && termination_pin) |=> termination_on)
      else $error("termination not following pin");
   a_leveling_no_dyn: assert property (@(posedge clk) disable iff (!rst_sync)
      wl_bit |=> termination_select != 2'(mode_reg_pkg::TERM_WRITE))
      else $error("write termination during leveling");
   a_srt_doubles: assert property (@(posedge clk) disable iff (!rst_sync)
      srt_bit |=> double_refresh_rate) else $error("self refresh rate not doubled");
   a_asr_hot: assert property (@(posedge clk) disable iff (!rst_sync)
      (asr_bit && hot_case) |=> double_refresh_rate) else $error("auto refresh not doubled");
   a_normal_rate: assert property (@(posedge clk) disable iff (!rst_sync)
      (!srt_bit && !asr_bit) |=> !double_refresh_rate) else $error("rate doubled without cause");
   a_wl_sum: assert property (@(posedge clk) disable iff (!rst_sync)
      ##1 overall_write_latency == 5'(cas_write_latency) + 5'(additive_latency))
      else $error("write latency sum wrong");
   a_mask_sharing: assert property (@(posedge clk) disable iff (!rst_sync)
      data_mask_enable != termination_strobe_n_used) else $error("mask and strobe both on");
   a_strobe_follows: assert property (@(posedge clk) disable iff (!rst_sync)
      $rose(termination_on) && strobe_en && $past(strobe_en) |-> termination_strobe_active)
      else $error("strobe pair not terminated");
   a_one_reset: assert property (@(posedge clk) disable iff (!rst_sync)
      $rose(rst_sync) |-> mode_register_one == mode_reg_pkg::MODE_REGISTER_ONE_RESET)
      else $error("register one not cleared");
   a_write_swap: assert property (@(posedge clk) disable iff (!rst_sync)
      (term_allowed && dyn_enabled && write_burst && termination_pin)
      |=> termination_select == 2'(mode_reg_pkg::TERM_WRITE)) else $error("no write termination");

   // ------------------------------------------------------------
   // Decode checks
   // ------------------------------------------------------------
   a_div_code_one: assert property (@(posedge clk) disable iff (!rst_sync)
      nom_code == 3'h1
      |=> nominal_termination == mode_reg_pkg::DIV_CODE1)
      else $error("nominal divisor wrong for code one");
   a_div_code_two: assert property (@(posedge clk) disable iff (!rst_sync)
      nom_code == 3'h2
      |=> nominal_termination == mode_reg_pkg::DIV_CODE2)
      else $error("nominal divisor wrong for code two");
   a_div_code_three: assert property (@(posedge clk) disable iff (!rst_sync)
      nom_code == 3'h3
      |=> nominal_termination == mode_reg_pkg::DIV_CODE3)
      else $error("nominal divisor wrong for code three");
   a_div_code_four: assert property (@(posedge clk) disable iff (!rst_sync)
      nom_code == 3'h4
      |=> nominal_termination == mode_reg_pkg::DIV_CODE4)
      else $error("nominal divisor wrong for code four");
   a_div_code_five: assert property (@(posedge clk) disable iff (!rst_sync)
      nom_code == 3'h5
      |=> nominal_termination == mode_reg_pkg::DIV_CODE5)
      else $error("nominal divisor wrong for code five");
   a_div_code_off: assert property (@(posedge clk) disable iff (!rst_sync)
      (nom_code == 3'h0 || nom_code > 3'h5)
      |=> nominal_termination == 4'h0)
      else $error("divisor shown for off or reserved code");
   a_al_zero: assert property (@(posedge clk) disable iff (!rst_sync)
      al_code == mode_reg_pkg::AL_ZERO
      |=> additive_latency == 4'h0)
      else $error("additive latency not zero");
   a_al_minus_one: assert property (@(posedge clk) disable iff (!rst_sync)
      al_code == mode_reg_pkg::AL_CL_MINUS_ONE
      |=> additive_latency == $past(cas_latency) - 4'h1)
      else $error("additive latency not cl minus one");
   a_al_minus_two: assert property (@(posedge clk) disable iff (!rst_sync)
      al_code == mode_reg_pkg::AL_CL_MINUS_TWO
      |=> additive_latency == $past(cas_latency) - 4'h2)
      else $error("additive latency not cl minus two");
   a_al_reserved: assert property (@(posedge clk) disable iff (!rst_sync)
      al_code == 2'h3
      |=> additive_latency_reserved && additive_latency == 4'h0)
      else $error("reserved latency code not flagged");
   a_leveling_out: assert property (@(posedge clk) disable iff (!rst_sync)
      1'b1
      |=> write_leveling == $past(wl_bit))
      else $error("write leveling output wrong");
   a_wr_term_out: assert property (@(posedge clk) disable iff (!rst_sync)
      1'b1
      |=> write_termination == $past(wr_code))
      else $error("write termination field wrong");
   a_cwl_decode: assert property (@(posedge clk) disable iff (!rst_sync)
      1'b1
      |=> cas_write_latency == mode_reg_pkg::CWL_BASE + {1'b0, $past(cwl_code)})
      else $error("cas write latency wrong");
   a_not_allowed_off: assert property (@(posedge clk) disable iff (!rst_sync)
      !term_allowed
      |=> !termination_on && termination_select == 2'(mode_reg_pkg::TERM_HIGH_Z))
      else $error("termination on while not allowed");
   a_pin_low_off: assert property (@(posedge clk) disable iff (!rst_sync)
      !termination_pin
      |=> !termination_on)
      else $error("termination on with pin low");
   a_strobe_off: assert property (@(posedge clk) disable iff (!rst_sync)
      !strobe_en
      |=> !termination_strobe_active)
      else $error("strobe pair terminated while disabled");
   a_nominal_alone: assert property (@(posedge clk) disable iff (!rst_sync)
      (term_allowed && nom_enabled && termination_pin && !write_burst)
      |=> termination_select == 2'(mode_reg_pkg::TERM_NOMINAL))
      else $error("nominal termination not selected");
   a_asr_out: assert property (@(posedge clk) disable iff (!rst_sync)
      1'b1
      |=> automatic_self_refresh == $past(asr_bit))
      else $error("automatic self refresh output wrong");
   a_srt_out: assert property (@(posedge clk) disable iff (!rst_sync)
      1'b1
      |=> self_refresh_temperature == $past(srt_bit))
      else $error("self refresh temperature output wrong");
endmodule

// file: mode_reg_ctrl_model.sv
// Memory controller model: issues mode register set commands and drives the termination pin
`timescale 1ns/10ps
module mode_reg_ctrl_model #(
   parameter int unsigned X8_PART = 1,
   parameter int unsigned SET_DELAY = 4
) (
   input wire logic clk,
   input wire logic odt_request,
   input wire logic read_active,
   output logic mrs_valid,
   output logic [2:0] mrs_select,
   output logic [18:0] mrs_data,
   output logic termination_pin
);
   // ------------------------------------------------------------
   // Command side
   // ------------------------------------------------------------
   assign termination_pin = odt_request & ~read_active;
   initial begin
      mrs_valid = 1'b0;
      mrs_select = 3'h0;
      mrs_data = 19'h00000;
   end
   task automatic mrs(input logic [2:0] sel, input logic [18:0] data);
      logic [18:0] word;
      word = data;
      word[11] = word[11] & (X8_PART != 0);
      if (sel == mode_reg_pkg::SEL_MODE_REGISTER_TWO) begin
         word = word & ~mode_reg_pkg::MR2_RESERVED_MASK;
         word[6] = word[6] & ~word[7];
      end
      @(posedge clk);
      mrs_valid <= 1'b1;
      mrs_select <= sel;
      mrs_data <= word;
      @(posedge clk);
      mrs_valid <= 1'b0;
      // Released lines flip rather than hold, so stale data never looks like a command
      mrs_select <= ~sel;
      mrs_data <= ~word;
      repeat (SET_DELAY) @(posedge clk);
   endtask
endmodule

// file: testbench.sv
// Self-checking bench for the mode register feature decode
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, init_done = 1'b0, read_active = 1'b0, self_refresh = 1'b0;
   logic write_burst = 1'b0, hot_case = 1'b0, odt_request = 1'b0, mrs_valid, termination_pin;
   logic termination_strobe_active, termination_strobe_n_used, data_mask_enable, termination_on, write_leveling;
   logic additive_latency_reserved, automatic_self_refresh, self_refresh_temperature, double_refresh_rate;
   logic [2:0] mrs_select;
   logic [18:0] mrs_data;
   logic [1:0] termination_select, write_termination;
   logic [3:0] cas_latency = 4'h9, nominal_termination, additive_latency, cas_write_latency;
   logic [4:0] overall_write_latency;
   logic [3:0] rtt_div [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc, 4'h8, 4'h0, 4'h0};
   int miscompares = 0;
   int cmp_count = 0;
   always #20 clk = ~clk;
   mode_reg_features #(.X8_PART(1)) mode_reg_features_inst (.*);
   mode_reg_ctrl_model #(.X8_PART(1), .SET_DELAY(4)) mode_reg_ctrl_model_inst (.*);
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] sel, input logic [18:0] d);
      mode_reg_ctrl_model_inst.mrs(sel, d);
      #1;
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tick(3);
   endtask
   // Inputs packed as odt, init, read, self refresh, write burst; result as on, select
   task automatic term_case(input logic [4:0] in, input logic [2:0] exp);
      @(posedge clk);
      {odt_request, init_done, read_active, self_refresh, write_burst} <= in;
      tick(2);
      check(termination_on, exp[2]);
      check(termination_select, exp[1:0]);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_reg_one;
      logic [18:0] d;
      logic [3:0] al;
      wr(3'h2, 19'h00018);
      for (int i = 0; i < 8; i++) begin
         d = 19'h00000;
         {d[9], d[6], d[2]} = i[2:0];
         d[4:3] = i[1:0];
         d[7] = i[2];
         d[11] = i[0];
         wr(3'h1, d);
         al = (i[1:0] == 2'h1) ? cas_latency - 4'h1 : (i[1:0] == 2'h2) ? cas_latency - 4'h2 : 4'h0;
         check(nominal_termination, rtt_div[i]);
         check(write_leveling, i[2]);
         check(additive_latency, al);
         check(additive_latency_reserved, i[1:0] == 2'h3);
         check(overall_write_latency, 5'h8 + {1'b0, al});
         check(termination_strobe_n_used, i[0]);
         check(data_mask_enable, !i[0]);
      end
   endtask
   task automatic test_reg_two;
      logic [18:0] d;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         hot_case <= k[2];
         d = 19'h00000;
         d[5:3] = k[2:0];
         d[10:9] = k[1:0];
         d[6] = k[0];
         d[7] = k[1];
         wr(3'h2, d);
         check(cas_write_latency, 4'h5 + {1'b0, k[2:0]});
         check(write_termination, k[1:0]);
         check(automatic_self_refresh, k[0] & !k[1]);
         check(self_refresh_temperature, k[1]);
         check(double_refresh_rate, k[1] | (k[0] & k[2]));
      end
   endtask
   task automatic test_termination;
      wr(3'h2, 19'h00400);
      wr(3'h1, 19'h00804);
      term_case(5'b11000, 3'b101);
      check(termination_strobe_active, 1'b1);
      term_case(5'b01000, 3'b000);
      term_case(5'b10000, 3'b000);
      term_case(5'b11100, 3'b000);
      term_case(5'b11010, 3'b000);
      term_case(5'b11001, 3'b110);
      wr(3'h1, 19'h00000);
      term_case(5'b11001, 3'b110);
      term_case(5'b11000, 3'b000);
      wr(3'h1, 19'h00084);
      term_case(5'b11001, 3'b101);
      term_case(5'b00000, 3'b000);
   endtask
   task automatic test_hold_and_reset;
      wr(3'h2, 19'h00010);
      wr(3'h1, 19'h00088);
      wr(3'h3, 19'h7ffff);
      check(write_leveling, 1'b1);
      check(additive_latency, 4'h8);
      check(cas_write_latency, 4'h7);
      do_reset;
      check(write_leveling, 1'b0);
      check(additive_latency, 4'h0);
      check(cas_write_latency, 4'h7);
   endtask
   initial begin
      do_reset;
      test_reg_one;
      test_reg_two;
      test_termination;
      test_hold_and_reset;
      stop_test;
   end
endmodule
